// File: common/pdf_pkg.sv
package pdf_pkg;

    // ------------------------------------------------------------
    // Formats
    // ------------------------------------------------------------
    localparam int          DIGITS       = 18;
    localparam logic [6:0]  LOAD_STEPS   = 7'h12;
    localparam logic [6:0]  DABBLE_STEPS = 7'h40;
    localparam logic [14:0] EXT_BIAS     = 15'h3FFF;
    localparam logic [14:0] EXT_INT_TOP  = 15'h403E;
    localparam logic [14:0] EXT_EXP_MAX  = 15'h7FFF;
    localparam logic [14:0] SGL_BIAS     = 15'h007F;
    localparam logic [63:0] MAX_MAG      = 64'h0DE0_B6B3_A763_FFFF;
    localparam logic [79:0] BCD_INDEF    = 80'hFFFF_C000_0000_0000_0000;
    localparam logic [3:0]  DIGIT_MAX    = 4'h9;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SIGN_BIT   = 79;
    localparam int EXP_LSB    = 64;
    localparam int INT_BIT    = 63;
    localparam int FRAC_MSB   = 62;
    localparam int SGL_FR_LSB = 40;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [79:0] RST_WIDE  = 80'h0;
    localparam logic [31:0] RST_SGL   = 32'h0;
    localparam logic [63:0] RST_MAG   = 64'h0;
    localparam logic [71:0] RST_BCD   = 72'h0;
    localparam logic [14:0] RST_EXP   = 15'h0;
    localparam logic [6:0]  RST_CNT   = 7'h0;
    localparam logic [6:0]  RST_VALUE = 7'h0;

    typedef enum logic [1:0] {
        PDF_OP_LOAD_DECIMAL_TO_FLOAT,
        PDF_OP_STORE_DECIMAL_AND_POP,
        PDF_OP_DIGIT_CHECK
    } pdf_op_t;

    typedef enum {
        PDF_IDLE,
        PDF_LOAD_ACC,
        PDF_LOAD_NORM,
        PDF_STORE_SHIFT,
        PDF_STORE_DABBLE
    } pdf_state_t;

endpackage

// File: rtl/pdf_convert.sv
`timescale 1ns/1ns
// Functional notes
// - A decimal digit is four bits, valid values zero to nine.
// - Unpacked digit value comes from the low nibble of the byte.
// - In packed bytes the upper nibble digit is more significant.
// - 80-bit decimal holds 18 digits in nine low bytes, LSD at byte zero.
// - Sign is top bit of the top byte; other seven bits ignored.
// - Negative decimals are sign-magnitude; only the sign bit differs.
// - Magnitude is at most ten to the eighteenth minus one.
// - Decimal load converts exactly to double extended float.
// - Masked invalid store writes the decimal indefinite pattern.
// - Float is sign, integer bit plus fraction, and power-of-two exponent.
// - Single-precision exponent carries a bias of 127.
// - Nonzero significands normalize to integer one, exponent down per shift.
// - Extended integer bit is bit 63, fraction top bit 62.
// - Extended exponent bias is 16383; format is ten bytes.
module pdf_convert (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic [1:0]  op,
    input  wire logic [79:0] bcd_in,
    input  wire logic [79:0] fp_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        byte_packed,
    input  wire logic        byte_muldiv,
    output logic             busy,
    output logic             done,
    output logic [79:0]      fp_out,
    output logic [31:0]      single_out,
    output logic [79:0]      bcd_out,
    output logic             invalid,
    output logic             digit_error,
    output logic [6:0]       digit_value
);

    typedef struct packed {
        pdf_pkg::pdf_state_t state;
        logic [63:0]         mag;
        logic [71:0]         bcd;
        logic [14:0]         exp;
        logic                sign;
        logic [6:0]          cnt;
        logic                busy;
        logic                done;
        logic [79:0]         fp_out;
        logic [31:0]         single_out;
        logic [79:0]         bcd_out;
        logic                invalid;
        logic                digit_error;
        logic [6:0]          digit_value;
    } pdf_regs_t;

    pdf_regs_t   r_reg;
    pdf_regs_t   r_next;
    logic [71:0] adj;

    // ------------------------------------------------------------
    // Double-dabble digit correction
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < pdf_pkg::DIGITS; gi++)
        begin : g_adj
            always_comb
            begin
                if (r_reg.bcd[4*gi +: 4] > 4'h4)
                    adj[4*gi +: 4] = r_reg.bcd[4*gi +: 4] + 4'h3;
                else
                    adj[4*gi +: 4] = r_reg.bcd[4*gi +: 4];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [3:0]  dig;
        logic [3:0]  hi;
        logic [3:0]  lo;
        logic [14:0] sexp;
        dig  = r_reg.bcd[71:68];
        hi   = byte_in[7:4];
        lo   = byte_in[3:0];
        sexp = r_reg.exp - pdf_pkg::EXT_BIAS + pdf_pkg::SGL_BIAS;
        r_next      = r_reg;
        r_next.done = 1'b0;
        unique case (r_reg.state)
            pdf_pkg::PDF_IDLE:
            begin
                if (start)
                begin
                    r_next.invalid     = 1'b0;
                    r_next.digit_error = 1'b0;
                    if (op == 2'(pdf_pkg::PDF_OP_LOAD_DECIMAL_TO_FLOAT))
                    begin
                        r_next.sign  = bcd_in[pdf_pkg::SIGN_BIT];
                        r_next.bcd   = bcd_in[71:0];
                        r_next.mag   = pdf_pkg::RST_MAG;
                        r_next.exp   = pdf_pkg::EXT_INT_TOP;
                        r_next.cnt   = pdf_pkg::LOAD_STEPS;
                        r_next.busy  = 1'b1;
                        r_next.state = pdf_pkg::PDF_LOAD_ACC;
                    end
                    else if (op == 2'(pdf_pkg::PDF_OP_STORE_DECIMAL_AND_POP))
                    begin
                        r_next.sign = fp_in[pdf_pkg::SIGN_BIT];
                        r_next.exp  = fp_in[78:pdf_pkg::EXP_LSB];
                        r_next.mag  = fp_in[pdf_pkg::INT_BIT:0];
                        r_next.bcd  = pdf_pkg::RST_BCD;
                        if (fp_in[78:pdf_pkg::EXP_LSB] == pdf_pkg::EXT_EXP_MAX ||
                            fp_in[78:pdf_pkg::EXP_LSB] > pdf_pkg::EXT_INT_TOP)
                        begin
                            // Infinity, NaN or far too large
                            r_next.bcd_out = pdf_pkg::BCD_INDEF;
                            r_next.invalid = 1'b1;
                            r_next.done    = 1'b1;
                        end
                        else if (fp_in[78:pdf_pkg::EXP_LSB] < pdf_pkg::EXT_BIAS)
                        begin
                            // Below one truncates to zero
                            r_next.mag   = pdf_pkg::RST_MAG;
                            r_next.cnt   = pdf_pkg::DABBLE_STEPS;
                            r_next.busy  = 1'b1;
                            r_next.state = pdf_pkg::PDF_STORE_DABBLE;
                        end
                        else
                        begin
                            r_next.cnt   = 7'(pdf_pkg::EXT_INT_TOP - fp_in[78:pdf_pkg::EXP_LSB]);
                            r_next.busy  = 1'b1;
                            r_next.state = pdf_pkg::PDF_STORE_SHIFT;
                        end
                    end
                    else
                    begin
                        r_next.done = 1'b1;
                        if (byte_packed)
                        begin
                            r_next.digit_value = 7'({3'h0, hi} * 7'h0A + {3'h0, lo});
                            r_next.digit_error = (hi > pdf_pkg::DIGIT_MAX) || (lo > pdf_pkg::DIGIT_MAX);
                        end
                        else
                        begin
                            r_next.digit_value = {3'h0, lo};
                            // Nonzero high nibble only matters for mul/div
                            r_next.digit_error = (lo > pdf_pkg::DIGIT_MAX) ||
                                                 (byte_muldiv && hi != 4'h0);
                        end
                    end
                end
            end
            pdf_pkg::PDF_LOAD_ACC:
            begin
                // Most significant digit first: mag = mag*10 + digit
                r_next.mag = (r_reg.mag << 3) + (r_reg.mag << 1) + {60'h0, dig};
                if (dig > pdf_pkg::DIGIT_MAX)
                    r_next.digit_error = 1'b1;
                r_next.bcd = {r_reg.bcd[67:0], 4'h0};
                r_next.cnt = r_reg.cnt - 7'h01;
                if (r_reg.cnt == 7'h01)
                    r_next.state = pdf_pkg::PDF_LOAD_NORM;
            end
            pdf_pkg::PDF_LOAD_NORM:
            begin
                if (r_reg.mag == pdf_pkg::RST_MAG)
                begin
                    // Zero keeps its sign, integer bit clear
                    r_next.fp_out     = {r_reg.sign, 79'h0};
                    r_next.single_out = {r_reg.sign, 31'h0};
                    r_next.busy       = 1'b0;
                    r_next.done       = 1'b1;
                    r_next.state      = pdf_pkg::PDF_IDLE;
                end
                else if (r_reg.mag[pdf_pkg::INT_BIT])
                begin
                    r_next.fp_out     = {r_reg.sign, r_reg.exp, r_reg.mag};
                    // Single copy truncates the fraction
                    r_next.single_out = {r_reg.sign, sexp[7:0],
                                         r_reg.mag[pdf_pkg::FRAC_MSB:pdf_pkg::SGL_FR_LSB]};
                    r_next.busy       = 1'b0;
                    r_next.done       = 1'b1;
                    r_next.state      = pdf_pkg::PDF_IDLE;
                end
                else
                begin
                    r_next.mag = {r_reg.mag[62:0], 1'b0};
                    r_next.exp = r_reg.exp - 15'h0001;
                end
            end
            pdf_pkg::PDF_STORE_SHIFT:
            begin
                if (r_reg.cnt == pdf_pkg::RST_CNT)
                begin
                    if (r_reg.mag > pdf_pkg::MAX_MAG)
                    begin
                        r_next.bcd_out = pdf_pkg::BCD_INDEF;
                        r_next.invalid = 1'b1;
                        r_next.busy    = 1'b0;
                        r_next.done    = 1'b1;
                        r_next.state   = pdf_pkg::PDF_IDLE;
                    end
                    else
                    begin
                        r_next.cnt   = pdf_pkg::DABBLE_STEPS;
                        r_next.state = pdf_pkg::PDF_STORE_DABBLE;
                    end
                end
                else
                begin
                    // Fraction bits drop: truncation toward zero
                    r_next.mag = {1'b0, r_reg.mag[63:1]};
                    r_next.cnt = r_reg.cnt - 7'h01;
                end
            end
            pdf_pkg::PDF_STORE_DABBLE:
            begin
                r_next.bcd = {adj[70:0], r_reg.mag[63]};
                r_next.mag = {r_reg.mag[62:0], 1'b0};
                r_next.cnt = r_reg.cnt - 7'h01;
                if (r_reg.cnt == 7'h01)
                begin
                    r_next.bcd_out = {r_reg.sign, 7'h00, adj[70:0], r_reg.mag[63]};
                    r_next.busy    = 1'b0;
                    r_next.done    = 1'b1;
                    r_next.state   = pdf_pkg::PDF_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            r_reg.state       <= pdf_pkg::PDF_IDLE;
            r_reg.mag         <= pdf_pkg::RST_MAG;
            r_reg.bcd         <= pdf_pkg::RST_BCD;
            r_reg.exp         <= pdf_pkg::RST_EXP;
            r_reg.sign        <= 1'b0;
            r_reg.cnt         <= pdf_pkg::RST_CNT;
            r_reg.busy        <= 1'b0;
            r_reg.done        <= 1'b0;
            r_reg.fp_out      <= pdf_pkg::RST_WIDE;
            r_reg.single_out  <= pdf_pkg::RST_SGL;
            r_reg.bcd_out     <= pdf_pkg::RST_WIDE;
            r_reg.invalid     <= 1'b0;
            r_reg.digit_error <= 1'b0;
            r_reg.digit_value <= pdf_pkg::RST_VALUE;
        end
        else
            r_reg <= r_next;
    end

    assign busy        = r_reg.busy;
    assign done        = r_reg.done;
    assign fp_out      = r_reg.fp_out;
    assign single_out  = r_reg.single_out;
    assign bcd_out     = r_reg.bcd_out;
    assign invalid     = r_reg.invalid;
    assign digit_error = r_reg.digit_error;
    assign digit_value = r_reg.digit_value;

endmodule

// File: tb/pdf_convert_assertions.sv
`timescale 1ns/1ns
module pdf_convert_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        start,
    input wire logic [1:0]  op,
    input wire logic [79:0] bcd_in,
    input wire logic [79:0] fp_in,
    input wire logic [7:0]  byte_in,
    input wire logic        byte_packed,
    input wire logic        byte_muldiv,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [79:0] fp_out,
    input wire logic [31:0] single_out,
    input wire logic [79:0] bcd_out,
    input wire logic        invalid,
    input wire logic        digit_error,
    input wire logic [6:0]  digit_value
);
    wire acc;
    wire chk;
    wire [14:0] ex;
    assign acc = start && !busy;
    assign chk = acc && op[1];
    assign ex = fp_out[78:64];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    check_time_a: assert property (chk |=> done && !busy) else $error("check late");
    packed_err_a: assert property (chk && byte_packed && (byte_in[7:4] > 4'h9 || byte_in[3:0] > 4'h9)
        |=> digit_error) else $error("bad digit missed");
    packed_val_a: assert property (chk && byte_packed && byte_in[7:4] <= 4'h9 && byte_in[3:0] <= 4'h9
        |=> !digit_error && digit_value == {3'h0, $past(byte_in[7:4])} * 7'h0A + {3'h0, $past(byte_in[3:0])})
        else $error("packed value");
    unpack_val_a: assert property (chk && !byte_packed |=> digit_value == {3'h0, $past(byte_in[3:0])})
        else $error("unpacked value");
    muldiv_err_a: assert property (chk && !byte_packed && byte_muldiv && byte_in[7:4] != 4'h0
        |=> digit_error) else $error("high nibble missed");
    store_indef_a: assert property (acc && op == 2'h1 && fp_in[78:64] == 15'h7FFF
        |=> done && invalid && bcd_out == pdf_pkg::BCD_INDEF) else $error("indefinite");
    load_time_a: assert property (acc && op == 2'h0 |=> busy [*8] ##[12:76] done) else $error("load time");
    int_bit_a: assert property (fp_out[63] == (ex != 15'h0)) else $error("integer bit");
    exp_range_a: assert property (ex != 15'h0 |-> ex >= pdf_pkg::EXT_BIAS && ex <= pdf_pkg::EXT_INT_TOP)
        else $error("exponent range");
    sgl_bias_a: assert property (ex != 15'h0 |-> single_out[31] == fp_out[79]
        && single_out[30:23] == 8'(ex - pdf_pkg::EXT_BIAS + pdf_pkg::SGL_BIAS)) else $error("single bias");
    cover property (acc && op == 2'h0);
    cover property (acc && op == 2'h1 ##[1:200] done);
    cover property (busy && start);
endmodule
bind pdf_convert pdf_convert_checker i_chk (.clk(clk), .reset(reset), .start(start), .op(op),
    .bcd_in(bcd_in), .fp_in(fp_in), .byte_in(byte_in), .byte_packed(byte_packed), .byte_muldiv(byte_muldiv),
    .busy(busy), .done(done), .fp_out(fp_out), .single_out(single_out), .bcd_out(bcd_out),
    .invalid(invalid), .digit_error(digit_error), .digit_value(digit_value));

// File: tb/pdf_convert_bench.sv
`timescale 1ns/1ns
module pdf_convert_bench;
    logic        clk, reset, start, byte_packed, byte_muldiv, busy, done, invalid, digit_error;
    logic [1:0]  op;
    logic [79:0] bcd_in, fp_in, fp_out, bcd_out;
    logic [7:0]  byte_in;
    logic [31:0] single_out;
    logic [6:0]  digit_value;
    int          bad_count, samples_checked;
    pdf_convert i_dut (.clk(clk), .reset(reset), .start(start), .op(op), .bcd_in(bcd_in), .fp_in(fp_in),
        .byte_in(byte_in), .byte_packed(byte_packed), .byte_muldiv(byte_muldiv), .busy(busy), .done(done),
        .fp_out(fp_out), .single_out(single_out), .bcd_out(bcd_out), .invalid(invalid),
        .digit_error(digit_error), .digit_value(digit_value));
    pdf_pipe_model i_pipe (.clk(clk), .done(done), .start(start), .op(op), .bcd_in(bcd_in), .fp_in(fp_in),
        .byte_in(byte_in), .byte_packed(byte_packed), .byte_muldiv(byte_muldiv));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task end_sim;
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [79:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task go(input logic [1:0] o, input logic [79:0] b, f, input logic [7:0] y, input logic p, m, k);
        logic ok;
        i_pipe.run(o, b, f, y, p, m, k, ok);
        if (ok !== 1'b1)
        begin
            bad_count++;
            end_sim;
        end
    endtask
    function automatic logic [63:0] bin_of(input logic [71:0] d);
        logic [63:0] v;
        v = 64'h0;
        for (int i = 17; i >= 0; i--)
            v = v * 64'hA + 64'(d[4*i +: 4]);
        return v;
    endfunction
    function automatic logic [79:0] fp_of(input logic s, input logic [63:0] m);
        logic [14:0] e;
        e = pdf_pkg::EXT_INT_TOP;
        if (m == 64'h0)
            return {s, 79'h0};
        while (!m[63])
        begin
            m = m << 1;
            e = e - 15'h1;
        end
        return {s, e, m};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_digits;
        logic [7:0] yb[6] = '{8'h45, 8'h4A, 8'hF7, 8'hF7, 8'h07, 8'h99};
        logic [1:0] pm[6] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h2};
        logic [7:0] ev[6] = '{8'h2D, 8'h80, 8'h07, 8'h80, 8'h07, 8'h63};
        for (int i = 0; i < 6; i++)
        begin
            go((i == 5) ? 2'h3 : 2'h2, 80'h0, 80'h0, yb[i], pm[i][1], pm[i][0], 1'b0);
            if (ev[i][7])
                chk(digit_error, 1'b1);
            else
                chk({digit_error, digit_value}, {1'b0, ev[i][6:0]});
        end
    endtask
    task ld(input logic [79:0] b, input logic k);
        logic [79:0] e;
        e = fp_of(b[79], bin_of(b[71:0]));
        go(2'h0, b, 80'h0, 8'h0, 1'b0, 1'b0, k);
        chk(fp_out, e);
        if (e[78:64] != 15'h0)
            chk(single_out, {e[79], 8'(e[78:64] - pdf_pkg::EXT_BIAS + pdf_pkg::SGL_BIAS), e[62:40]});
        else
            chk(single_out, {e[79], 31'h0});
    endtask
    task st(input logic [79:0] f, e);
        go(2'h1, 80'h0, f, 8'h0, 1'b0, 1'b0, 1'b0);
        chk(bcd_out, e);
        chk(invalid, e == pdf_pkg::BCD_INDEF);
    endtask
    task chk_idle;
        chk(fp_out, 80'h0);
        chk(bcd_out, 80'h0);
        chk({single_out, digit_value, busy, done, invalid, digit_error}, 80'h0);
    endtask
    task t_busy;
        go(2'h2, 80'h0, 80'h0, 8'h11, 1'b1, 1'b0, 1'b0);
        ld(80'h7, 1'b1);
        chk(digit_value, 7'h0B);
        // Digit above nine inside a load operand
        go(2'h0, 80'hA, 80'h0, 8'h0, 1'b0, 1'b0, 1'b0);
        chk(digit_error, 1'b1);
    endtask
    // Reset between operations must clear every result, then work resumes
    task t_reset;
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk_idle;
        go(2'h2, 80'h0, 80'h0, 8'h38, 1'b1, 1'b0, 1'b0);
        chk({digit_error, digit_value}, {1'b0, 7'h26});
    endtask
    initial
    begin
        reset = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk_idle;
        t_digits;
        ld(80'h1, 1'b0);
        ld({8'h80, 72'h99_9999_9999_9999_9999}, 1'b0);
        ld({8'h80, 72'h0}, 1'b0);
        ld({8'h7F, 72'h45}, 1'b0);
        ld({8'h00, 72'h12_3456_7890_1234_5678}, 1'b0);
        st(fp_of(1'b0, 64'h1), 80'h1);
        st(fp_of(1'b1, 64'd123), {8'h80, 72'h123});
        st({1'b0, 15'h4000, 64'hB000_0000_0000_0000}, 80'h2);
        st(fp_of(1'b0, pdf_pkg::MAX_MAG), {8'h00, 72'h99_9999_9999_9999_9999});
        st(fp_of(1'b0, 64'h0DE0_B6B3_A764_0000), pdf_pkg::BCD_INDEF);
        st({1'b0, 15'h7FFF, 64'h8000_0000_0000_0000}, pdf_pkg::BCD_INDEF);
        st({1'b0, 15'h4040, 64'h8000_0000_0000_0000}, pdf_pkg::BCD_INDEF);
        st({1'b1, 15'h3FFE, 64'hC000_0000_0000_0000}, {8'h80, 72'h0});
        t_busy;
        t_reset;
        end_sim;
    end
endmodule

// File: tb/pdf_pipe_model.sv
`timescale 1ns/1ns
module pdf_pipe_model (
    input  wire logic        clk,
    input  wire logic        done,
    output logic             start,
    output logic [1:0]       op,
    output logic [79:0]      bcd_in,
    output logic [79:0]      fp_in,
    output logic [7:0]       byte_in,
    output logic             byte_packed,
    output logic             byte_muldiv
);
    initial {start, op, bcd_in, fp_in, byte_in, byte_packed, byte_muldiv} = '0;
    // Drives every load operand as given, the indefinite pattern included
    task run(input logic [1:0] o, input logic [79:0] b, f, input logic [7:0] y, input logic p, m, k,
             output logic ok);
        ok = 1'b0;
        @(negedge clk);
        {start, op, bcd_in, fp_in, byte_in, byte_packed, byte_muldiv} = {1'b1, o, b, f, y, p, m};
        for (int n = 0; n < 300 && !ok; n++)
        begin
            @(negedge clk);
            start = k && n == 3;
            if (k && n == 3)
                {op, byte_in, byte_packed} = {2'h2, 8'h99, 1'b1};
            ok = (done === 1'b1);
        end
        // Released operands show the inverse, so stale values never pass
        {bcd_in, fp_in, byte_in} = ~{bcd_in, fp_in, byte_in};
    endtask
endmodule
